// ===== core/mhcr_regs_top.v
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "mhcr_regs.vh"
module mhcr_regs_top #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Transmit FIFO push side
  output reg [15:0] txWord,
  output reg txPush,
  // Receive FIFO pop side
  input wire [15:0] rxWord,
  output reg rxPop,
  // Events from the sample engine
  input wire wakeEvent,
  input wire rxOverrun,
  input wire txUnderrun,
  input wire hostIrqEvent,
  input wire timeoutEvent,
  // External interrupt pin
  input wire extIrqPin,
  // Wake output
  output wire wakeOut,
  // Control outputs
  output wire [1:0] powerState,
  output wire sleepMode,
  output wire frontEndPowerdown_n,
  output wire frontEndReset_n,
  output reg startPulse,
  output reg transmitArmPulse,
  output wire timeoutReset,
  output wire hostIrq,
  // Side registers
  output reg [7:0] external_output_latch,
  input wire [3:0] external_input_view,
  output reg [11:0] toutFfsz,
  input wire [11:0] errorTally,
  output reg [7:0] clkDivider,
  // Interrupt
  output wire irq
);

  reg wakeFlag;
  reg wakeEnable;
  reg [1:0] pmState;
  reg [15:0] control;
  wire [3:0] statusFlags;
  wire [3:0] irqStatus;
  reg [3:0] irqMask;
  reg [2:0] extSync;
  reg extPrev;
  reg ctlPrevStart;
  reg ctlPrevTx;
  reg awHeld;
  reg wHeld;
  reg [ADDR_W-1:0] awAddr;
  reg [31:0] wData;
  reg [3:0] wStrb;
  reg [31:0] readWord;
  reg readErr;
  reg wrMapped;

  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire doRead = s_axi_arvalid && !s_axi_rvalid;
  wire lowWr = wStrb[0] && wStrb[1];
  wire wrData = doWrite && awAddr == `MHCR_ADDR_DATA && lowWr;
  wire wrCtrl = doWrite && awAddr == `MHCR_ADDR_CTRL;
  wire wrPm = doWrite && awAddr == `MHCR_ADDR_PM;
  wire rdStatus = doRead && s_axi_araddr == `MHCR_ADDR_CTRL;
  wire rdIrqSt = doRead && s_axi_araddr == `MHCR_ADDR_IRQST;

  assign s_axi_awready = !awHeld;
  assign s_axi_wready = !wHeld;
  assign s_axi_arready = !s_axi_rvalid;

  wire extResync = (extSync[2] == extSync[1]) ? extSync[2] : extPrev;
  wire extLevel = control[`MHCR_CTL_XPASS] ? extSync[1] : extResync;
  wire extEdge = control[`MHCR_CTL_XEDGE] ? (extLevel && !extPrev) : (!extLevel && extPrev);
  wire extEvent = control[`MHCR_CTL_XEN] && extEdge;

  // Write decode over the mapped addresses
  always @*
  begin
    wrMapped = 1'b0;
    if (awAddr == `MHCR_ADDR_DATA)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_CTRL)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_EXT)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_TOUT)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_CLKD)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_PM)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_IMASK)
      wrMapped = 1'b1;
    else if (awAddr == `MHCR_ADDR_IRQST)
      wrMapped = 1'b1;
  end

  // AXI write capture in either order
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= {ADDR_W{1'b0}};
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MHCR_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `MHCR_RESP_OK : `MHCR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // External request: three stage synchroniser, edge after stages two and three, or after stage two alone when XPASS is set
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extSync <= 3'h0;
      extPrev <= 1'b0;
    end
    else
    begin
      extSync <= {extSync[1:0], extIrqPin};
      extPrev <= extLevel;
    end
  end

  // Registers written by software
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wakeFlag <= 1'b0;
      wakeEnable <= 1'b0;
      pmState <= `MHCR_PM_STATE_RST;
      control <= `MHCR_CTL_RST;
      external_output_latch <= 8'h00;
      toutFfsz <= 12'h000;
      clkDivider <= 8'h00;
      irqMask <= 4'h0;
      txWord <= 16'h0000;
      txPush <= 1'b0;
    end
    else
    begin
      txPush <= 1'b0;
      if (wakeEvent)
        wakeFlag <= 1'b1;
      else if (wrPm && wStrb[1] && wData[`MHCR_PM_FLAG])
        wakeFlag <= 1'b0;
      if (wrPm && wStrb[1])
        wakeEnable <= wData[`MHCR_PM_EN];
      if (wrPm && wStrb[0] && wData[1:0] != `MHCR_PM_D1)
        pmState <= wData[1:0];
      if (wrCtrl && lowWr)
        control <= wData[15:0];
      if (wrData)
      begin
        txWord <= wData[15:0];
        txPush <= 1'b1;
      end
      if (doWrite && awAddr == `MHCR_ADDR_EXT && wStrb[0])
        external_output_latch <= wData[7:0];
      if (doWrite && awAddr == `MHCR_ADDR_TOUT && lowWr)
        toutFfsz <= wData[11:0];
      if (doWrite && awAddr == `MHCR_ADDR_CLKD && wStrb[0])
        clkDivider <= wData[7:0];
      if (doWrite && awAddr == `MHCR_ADDR_IMASK && wStrb[0])
        irqMask <= wData[3:0];
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctlPrevStart <= 1'b0;
      ctlPrevTx <= 1'b0;
      startPulse <= 1'b0;
      transmitArmPulse <= 1'b0;
    end
    else
    begin
      ctlPrevStart <= control[`MHCR_CTL_START];
      ctlPrevTx <= control[`MHCR_CTL_TXARM];
      startPulse <= control[`MHCR_CTL_START] && !ctlPrevStart;
      transmitArmPulse <= control[`MHCR_CTL_TXARM] && !ctlPrevTx;
    end
  end

  // Event vectors in status and interrupt status register bit order
  wire [3:0] statusSet = {extEvent, hostIrqEvent, rxOverrun, txUnderrun};
  wire [3:0] irqSet = {txUnderrun, rxOverrun, extEvent, wakeEvent};

  // One sticky cell per flag; a set in the cycle of a clearing read wins
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < 4; bitIdx = bitIdx + 1)
    begin : gSticky
      reg stickyStatus;
      reg stickyIrq;
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stickyStatus <= 1'b0;
          stickyIrq <= 1'b0;
        end
        else
        begin
          if (statusSet[bitIdx])
            stickyStatus <= 1'b1;
          else if (rdStatus)
            stickyStatus <= 1'b0;
          if (irqSet[bitIdx])
            stickyIrq <= 1'b1;
          else if (rdIrqSt)
            stickyIrq <= 1'b0;
        end
      end
      assign statusFlags[bitIdx] = stickyStatus;
      assign irqStatus[bitIdx] = stickyIrq;
    end
  endgenerate

  // Read decode, an if chain over the mapped addresses
  always @*
  begin
    readWord = 32'h00000000;
    readErr = 1'b0;
    if (s_axi_araddr == `MHCR_ADDR_DATA)
      readWord = {16'h0000, rxWord};
    else if (s_axi_araddr == `MHCR_ADDR_CTRL)
      readWord = {28'h0000000, statusFlags};
    else if (s_axi_araddr == `MHCR_ADDR_EXT)
      readWord = {28'h0000000, external_input_view};
    else if (s_axi_araddr == `MHCR_ADDR_TOUT)
      readWord = {20'h00000, errorTally};
    else if (s_axi_araddr == `MHCR_ADDR_CLKD)
      readWord = 32'h00000000;
    else if (s_axi_araddr == `MHCR_ADDR_PM)
      readWord = {16'h0000, wakeFlag, 6'h00, wakeEnable, 6'h00, pmState};
    else if (s_axi_araddr == `MHCR_ADDR_IMASK)
      readWord = {28'h0000000, irqMask};
    else if (s_axi_araddr == `MHCR_ADDR_IRQST)
      readWord = {28'h0000000, irqStatus};
    else
      readErr = 1'b1;
  end

  // Read channel; the answer is registered from the decode
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MHCR_RESP_OK;
      rxPop <= 1'b0;
    end
    else
    begin
      rxPop <= 1'b0;
      if (doRead)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= readErr ? `MHCR_RESP_SLVERR : `MHCR_RESP_OK;
        rxPop <= (s_axi_araddr == `MHCR_ADDR_DATA);
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign wakeOut = wakeFlag && wakeEnable;
  assign powerState = pmState;
  assign sleepMode = control[`MHCR_CTL_SLEEP];
  assign frontEndPowerdown_n = control[`MHCR_CTL_PDN_N];
  assign frontEndReset_n = control[`MHCR_CTL_AFRST_N];
  assign timeoutReset = timeoutEvent && !control[`MHCR_CTL_TIMEOUT_RESET_DISABLE];
  assign hostIrq = control[`MHCR_CTL_HIRQ] && statusFlags[`MHCR_ST_HIRQ];
  assign irq = |(irqStatus & irqMask);

endmodule
`default_nettype wire

// ===== inc/mhcr_regs.vh
`ifndef MHCR_REGS_VH
`define MHCR_REGS_VH
// Byte addresses (local index times four; power management and interrupt mask and status at their own offsets)
`define MHCR_IDX_DATA 8'h00
`define MHCR_IDX_CTRL 8'h01
`define MHCR_IDX_EXT 8'h02
`define MHCR_IDX_TOUT 8'h03
`define MHCR_IDX_CLKD 8'h05
`define MHCR_ADDR_DATA 8'h00
`define MHCR_ADDR_CTRL 8'h04
`define MHCR_ADDR_EXT 8'h08
`define MHCR_ADDR_TOUT 8'h0c
`define MHCR_ADDR_CLKD 8'h14
`define MHCR_ADDR_PM 8'h44
`define MHCR_ADDR_IMASK 8'h80
`define MHCR_ADDR_IRQST 8'h84
// Power management field positions and reset
`define MHCR_PM_FLAG 15
`define MHCR_PM_EN 8
`define MHCR_PM_STATE_RST 2'h3
`define MHCR_PM_D0 2'h0
`define MHCR_PM_D1 2'h1
`define MHCR_PM_D2 2'h2
`define MHCR_PM_D3 2'h3
// Control word bits
`define MHCR_CTL_RST 16'h0000
`define MHCR_CTL_SLEEP 15
`define MHCR_CTL_PDN_N 14
`define MHCR_CTL_XEN 13
`define MHCR_CTL_XEDGE 12
`define MHCR_CTL_AFRST_N 11
`define MHCR_CTL_XPASS 10
`define MHCR_CTL_TIMEOUT_RESET_DISABLE 7
`define MHCR_CTL_HIRQ 6
`define MHCR_CTL_START 5
`define MHCR_CTL_TXARM 3
// Status word bits
`define MHCR_ST_XIRQ 3
`define MHCR_ST_HIRQ 2
`define MHCR_ST_OVR 1
`define MHCR_ST_UDR 0
// Interrupt status bits
`define MHCR_IS_WAKE 0
`define MHCR_IS_XIRQ 1
`define MHCR_IS_OVR 2
`define MHCR_IS_UDR 3
`define MHCR_RESP_OK 2'h0
`define MHCR_RESP_SLVERR 2'h2
`endif

// ===== test/mhcr_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module mhcr_far_side (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample FIFO sides
  input wire logic [15:0] txWord,
  input wire logic txPush,
  output logic [15:0] rxWord,
  input wire logic rxPop
);
  logic [15:0] popCount;
  logic [15:0] txSeen[$];
  assign rxWord = 16'ha5c3 ^ popCount;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      popCount <= 16'h0000;
    else if (rxPop)
      popCount <= popCount + 16'h0001;
  always @(posedge clk)
    if (txPush === 1'b1)
      txSeen.push_back(txWord);
endmodule
`default_nettype wire

// ===== test/mhcr_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mhcr_regs_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic txPush,
  input wire logic rxPop,
  input wire logic [1:0] powerState,
  input wire logic sleepMode,
  input wire logic frontEndPowerdown_n,
  input wire logic frontEndReset_n,
  input wire logic startPulse,
  input wire logic transmitArmPulse,
  input wire logic timeoutReset,
  input wire logic timeoutEvent,
  input wire logic wakeOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PS_RST: assert property ($rose(rst_n) |-> powerState == 2'h3)
    else $error("power state not D3hot after reset");
  AST_CTL_RST: assert property ($rose(rst_n) |-> !sleepMode && !frontEndPowerdown_n
    && !frontEndReset_n && !wakeOut) else $error("control outputs not at reset");
  AST_NO_D1: assert property (powerState != 2'h1)
    else $error("undefined power state reached");
  AST_TOUT: assert property (timeoutReset |-> timeoutEvent)
    else $error("time-out reset without event");
  AST_START: assert property (startPulse |=> !startPulse)
    else $error("start pulse longer than one cycle");
  AST_ARM: assert property ($rose(transmitArmPulse) |=> $fell(transmitArmPulse))
    else $error("transmit arm pulse longer than one cycle");
  AST_POP: assert property (rxPop |-> $rose(s_axi_rvalid))
    else $error("receive pop outside read answer");
  AST_PUSH: assert property (txPush |=> !txPush)
    else $error("transmit push repeated");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  cover property (txPush);
  cover property (rxPop);
  cover property (startPulse);
endmodule
bind mhcr_regs_top mhcr_regs_asserts u_mhcr_regs_asserts (.*);
`default_nettype wire

// ===== test/mhcr_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mhcr_regs_bench;
  logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd, w, seed;
  logic [3:0] s_axi_wstrb, external_input_view;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txPush, rxPop;
  wire [1:0] s_axi_bresp, s_axi_rresp, powerState;
  wire [31:0] s_axi_rdata;
  wire [15:0] txWord, rxWord;
  wire wakeOut, sleepMode, frontEndPowerdown_n, frontEndReset_n, irq, hostIrq;
  wire startPulse, transmitArmPulse, timeoutReset;
  wire [7:0] external_output_latch, clkDivider;
  wire [11:0] toutFfsz;
  logic wakeEvent, rxOverrun, txUnderrun, hostIrqEvent, timeoutEvent, extIrqPin;
  logic [11:0] errorTally;
  logic [1:0] ps, rsp;
  logic [15:0] txq[$];
  int mismatches, compares, starts, arms;
  mhcr_regs_top u_mhcr_regs_top (.*);
  mhcr_far_side u_mhcr_far_side (.*);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task rdt(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (startPulse === 1'b1) starts <= starts + 1;
    if (transmitArmPulse === 1'b1) arms <= arms + 1;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial
  begin
    seed = 32'h620cdad9;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, external_input_view, errorTally} = '0;
    {wakeEvent, rxOverrun, txUnderrun, hostIrqEvent, timeoutEvent, extIrqPin} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdt(8'h44);
    chk("power_mgmt_control_status", 32'h3, rd);
    chk("ctl", 0, {sleepMode, frontEndPowerdown_n, frontEndReset_n});
    wr(8'h44, 32'h8003);
    ps = 2'h3;
    for (int i = 0; i < 8; i++)
    begin
      w = rnd();
      w[1:0] = i[1:0];
      wr(8'h44, w);
      if (w[1:0] != 2'h1) ps = w[1:0];
      rdt(8'h44);
      chk("power_mgmt_control_status", {23'h0, w[8], 6'h0, ps}, rd);
      chk("powerState", ps, powerState);
    end
    $display("power state test done");
    wr(8'h80, 32'h1);
    wr(8'h44, 32'h100 | ps);
    @(posedge clk) wakeEvent <= 1'b1;
    @(posedge clk) wakeEvent <= 1'b0;
    rdt(8'h44);
    chk("power_mgmt_control_status", 32'h8100 | ps, rd);
    chk("wakeOut", 2'h3, {wakeOut, irq});
    wr(8'h44, 32'h100 | ps);
    rdt(8'h44);
    chk("power_mgmt_control_status", 32'h8100 | ps, rd);
    wr(8'h44, 32'h8100 | ps);
    chk("wakeOut", 0, wakeOut);
    rdt(8'h44);
    chk("power_mgmt_control_status", 32'h100 | ps, rd);
    wr(8'h44, {30'h0, ps});
    @(posedge clk) wakeEvent <= 1'b1;
    @(posedge clk) wakeEvent <= 1'b0;
    rdt(8'h44);
    chk("power_mgmt_control_status", 32'h8000 | ps, rd);
    chk("wakeOut", 0, wakeOut);
    rdt(8'h84);
    chk("irqStatus", 32'h2, {rd[3:0], irq});
    wr(8'h80, 32'h0);
    @(posedge clk) rxOverrun <= 1'b1;
    @(posedge clk) rxOverrun <= 1'b0;
    rdt(8'h84);
    chk("irqMasked", 32'h8, {rd[3:0], irq});
    $display("wake test done");
    for (int i = 0; i < 3; i++)
    begin
      w = rnd();
      txq.push_back(w[15:0]);
      wr(8'h00, w);
      rdt(8'h00);
      chk("rxWord", 16'ha5c3 ^ i[15:0], rd[15:0]);
    end
    foreach (txq[k]) chk("txWord", txq[k], u_mhcr_far_side.txSeen[k]);
    w = rnd();
    external_input_view <= w[3:0];
    errorTally <= w[27:16];
    wr(8'h08, w);
    wr(8'h0c, w);
    wr(8'h14, w);
    chk("sideOut", {w[7:0], w[11:0], w[7:0]}, {external_output_latch, toutFfsz, clkDivider});
    rdt(8'h08);
    chk("external_input_view", w[3:0], rd);
    rdt(8'h0c);
    chk("errorTally", w[27:16], rd);
    rdt(8'h30);
    chk("unmapped", 2'h2, rsp);
    $display("data test done");
    wr(8'h04, 32'hc800);
    chk("ctl", 3'h7, {sleepMode, frontEndPowerdown_n, frontEndReset_n});
    wr(8'h04, 32'h28);
    wr(8'h04, 32'h28);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h28);
    repeat (4) @(posedge clk);
    chk("pulses", 32'h22, {starts[3:0], arms[3:0]});
    timeoutEvent <= 1'b1;
    wr(8'h04, 32'h0);
    chk("timeoutReset", 1, timeoutReset);
    wr(8'h04, 32'h80);
    chk("timeoutReset", 0, timeoutReset);
    @(posedge clk) hostIrqEvent <= 1'b1;
    @(posedge clk) hostIrqEvent <= 1'b0;
    wr(8'h04, 32'h40);
    chk("hostIrq", 1, hostIrq);
    rdt(8'h04);
    chk("status", 32'hc, {rd[3:0], hostIrq});
    rdt(8'h04);
    chk("status", 0, rd[3:0]);
    wr(8'h04, 32'h3000);
    @(posedge clk) extIrqPin <= 1'b1;
    repeat (6) @(posedge clk);
    rdt(8'h04);
    chk("extRise", 4'h8, rd[3:0]);
    wr(8'h04, 32'h2000);
    @(posedge clk) extIrqPin <= 1'b0;
    repeat (6) @(posedge clk);
    rdt(8'h04);
    chk("extFall", 4'h8, rd[3:0]);
    wr(8'h04, 32'h1000);
    @(posedge clk) extIrqPin <= 1'b1;
    repeat (6) @(posedge clk);
    rdt(8'h04);
    chk("extOff", 4'h0, rd[3:0]);
    rdt(8'h84);
    chk("irqExt", 4'h2, rd[3:0]);
    wr(8'h80, 32'h2);
    wr(8'h04, 32'h2400);
    @(posedge clk) extIrqPin <= 1'b0;
    repeat (3) @(posedge clk);
    chk("extPassEarly", 0, irq);
    @(posedge clk);
    chk("extPass", 1, irq);
    rdt(8'h84);
    chk("irqPass", 4'h2, rd[3:0]);
    wr(8'h04, 32'h3000);
    @(posedge clk) extIrqPin <= 1'b1;
    repeat (4) @(posedge clk);
    chk("extSyncEarly", 0, irq);
    @(posedge clk);
    chk("extSync", 1, irq);
    $display("control test done");
    conclude();
  end
endmodule
`default_nettype wire
